//--- ocd_output_channels.sv
// Purpose: configuration and divider logic for eight clock/sysref output channels, 16 outputs
// Assumes: serial port pins are synchronous to clk_sys; sclk well below clk_sys
// Notes: 8-bit address/command byte (bit 7 set = read) then one data byte, msb first
`timescale 1ns/100ps
`include "ocd_params.svh"
module ocd_output_channels
  import ocd_pkg::*;
#(
  parameter int NUM_CH = `OCD_NUM_CH,
  parameter int NUM_OUT = `OCD_NUM_OUT
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic src_pll1_tick,
  input wire logic src_pll0_tick,
  input wire logic rf_oscillator_pin,
  output logic [NUM_OUT-1:0] out_level,
  output logic [NUM_OUT*`OCD_ANLG_W-1:0] output_analog_delay
);

  if (NUM_CH != `OCD_NUM_CH || NUM_OUT != `OCD_NUM_OUT) begin : g_chk
    $error("ocd_output_channels: channel map is fixed at 8 channels, 16 outputs");
  end

  // channel owning each output: A=1, B=2, C=2, D=2, E=3, F=2, G=1, H=3 outputs
  function automatic logic [2:0] ch_of_out(input int y);
    if (y < 1) return 3'd0;
    if (y < 3) return 3'd1;
    if (y < 5) return 3'd2;
    if (y < 7) return 3'd3;
    if (y < 10) return 3'd4;
    if (y < 12) return 3'd5;
    if (y < 13) return 3'd6;
    return 3'd7;
  endfunction

  // rf channels C and D may bypass to the external oscillator
  function automatic logic is_rf_ch(input logic [2:0] ch);
    return (ch == 3'd2) || (ch == 3'd3);
  endfunction

  logic [7:0] ctrl_r [NUM_CH];
  logic [7:0] stage_a_r [NUM_CH];
  logic [7:0] stage_b_r [NUM_CH];
  logic [7:0] wide_r [NUM_CH];
  logic [7:0] outdly_r [NUM_OUT];
  logic [7:0] sysref_shared_divider_setting_r;
  logic sync_r;

  ocd_spi_state_type state_r;
  logic sclk_prev_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] cmd_r;
  logic [7:0] rd_shift_r;
  logic [7:0] rd_data;
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;
  logic [7:0] wr_byte;
  logic wr_en;
  logic [6:0] wr_addr;

  assign sclk_rise = spi_sclk && !sclk_prev_r && !spi_cs_n;
  assign sclk_fall = !spi_sclk && sclk_prev_r && !spi_cs_n;
  assign byte_done = sclk_rise && (bit_cnt_r == 3'd7);
  assign wr_byte = {shift_r[6:0], spi_mosi};
  assign wr_en = byte_done && (state_r == OCD_SPI_DATA) && !cmd_r[7];
  assign wr_addr = cmd_r[6:0];

  // serial port framing; chip select high aborts any partial byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= OCD_SPI_IDLE;
      sclk_prev_r <= 1'b0;
      bit_cnt_r <= 3'd0;
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
    end else begin
      sclk_prev_r <= spi_sclk;
      if (spi_cs_n) begin
        state_r <= OCD_SPI_IDLE;
        bit_cnt_r <= 3'd0;
      end else begin
        if (state_r == OCD_SPI_IDLE) begin
          state_r <= OCD_SPI_ADDR;
        end
        if (sclk_rise) begin
          shift_r <= wr_byte;
          bit_cnt_r <= bit_cnt_r + 3'd1;
        end
        if (byte_done && state_r != OCD_SPI_DATA) begin
          cmd_r <= wr_byte;
          state_r <= OCD_SPI_DATA;
        end
      end
    end
  end

  // read mux: unmapped addresses read as zero
  always_comb begin
    rd_data = 8'h00;
    if (wr_byte[6:0] == `OCD_SYSREF_SHARED_ADDR) begin
      rd_data = sysref_shared_divider_setting_r;
    end else if (wr_byte[6:0] == `OCD_STATUS_ADDR) begin
      rd_data = 8'h00;
      for (int c = 0; c < NUM_CH; c++) begin
        rd_data[c] = ctrl_r[c][`OCD_CTRL_SYSREF_BIT];
      end
    end else if (wr_byte[6:5] == 2'b10) begin
      unique case (wr_byte[1:0])
        `OCD_CH_CTRL_OFS: rd_data = ctrl_r[wr_byte[4:2]];
        `OCD_CH_STAGE_A_OFS: rd_data = stage_a_r[wr_byte[4:2]];
        `OCD_CH_STAGE_B_OFS: rd_data = stage_b_r[wr_byte[4:2]];
        `OCD_CH_WIDE_OFS: rd_data = wide_r[wr_byte[4:2]];
      endcase
    end else if (wr_byte[6:4] == 3'b110) begin
      rd_data = outdly_r[wr_byte[3:0]];
    end
  end

  // read data leaves on falling sclk so the master samples on rising
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_shift_r <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else if (spi_cs_n) begin
      spi_miso_oe_n <= 1'b1;
      spi_miso <= 1'b0;
    end else if (byte_done && state_r != OCD_SPI_DATA && wr_byte[7]) begin
      rd_shift_r <= {rd_data[6:0], 1'b0};
      spi_miso <= rd_data[7];
      spi_miso_oe_n <= 1'b0;
    end else if (byte_done && state_r == OCD_SPI_DATA) begin
      spi_miso_oe_n <= 1'b1; // one data byte per frame
    end else if (sclk_fall && !spi_miso_oe_n && bit_cnt_r != 3'd0) begin
      spi_miso <= rd_shift_r[7];
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
    end
  end

  // register writes; any divider or mode change also fires a common sync
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctrl_r[c] <= `OCD_RST_CTRL;
        stage_a_r[c] <= `OCD_RST_STAGE_A;
        stage_b_r[c] <= `OCD_RST_STAGE_B;
        wide_r[c] <= `OCD_RST_WIDE;
      end
      for (int y = 0; y < NUM_OUT; y++) begin
        outdly_r[y] <= `OCD_RST_OUT;
      end
      sysref_shared_divider_setting_r <= `OCD_RST_SHARED;
      sync_r <= 1'b1; // first alignment straight out of reset
    end else begin
      sync_r <= 1'b0;
      if (wr_en) begin
        if (wr_addr == `OCD_SYSREF_SHARED_ADDR) begin
          sysref_shared_divider_setting_r <= wr_byte;
          sync_r <= 1'b1;
        end else if (wr_addr == `OCD_SYNC_ADDR) begin
          sync_r <= wr_byte[`OCD_SYNC_BIT];
        end else if (wr_addr[6:5] == 2'b10) begin
          sync_r <= 1'b1;
          unique case (wr_addr[1:0])
            `OCD_CH_CTRL_OFS: ctrl_r[wr_addr[4:2]] <= wr_byte;
            `OCD_CH_STAGE_A_OFS: stage_a_r[wr_addr[4:2]] <= wr_byte;
            `OCD_CH_STAGE_B_OFS: stage_b_r[wr_addr[4:2]] <= wr_byte;
            `OCD_CH_WIDE_OFS: wide_r[wr_addr[4:2]] <= wr_byte;
          endcase
        end else if (wr_addr[6:4] == 3'b110) begin
          outdly_r[wr_addr[3:0]] <= wr_byte; // delay changes are glitch-free, no resync
        end
      end
    end
  end

  logic [NUM_CH-1:0] ch_level;
  logic [3:0] shared_exp;

  assign shared_exp = ocd_exp(sysref_shared_divider_setting_r, `OCD_SHARED_MAX);

  // one divider per channel, each with its own copy of the shared sysref stage
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic src_sel;
    // source mux: pll1 path or pll0 path
    assign src_sel = ctrl_r[c][`OCD_CTRL_SRC_BIT] ? src_pll0_tick : src_pll1_tick;
    ocd_channel_divider #(
      .CNT_W(`OCD_RATIO_W),
      .WIDE_W(`OCD_WIDE_W)
    ) u_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .src_tick(src_sel),
      .sysref_mode(ctrl_r[c][`OCD_CTRL_SYSREF_BIT]),
      .stage_a(ocd_stage_a(stage_a_r[c])),
      .stage_b_exp(ocd_exp(stage_b_r[c], `OCD_STAGE_B_MAX)),
      .shared_exp(shared_exp),
      .wide_delay({ctrl_r[c][`OCD_CTRL_WIDE_MSB_BIT], wide_r[c]}),
      .sync(sync_r),
      .level(ch_level[c])
    );
  end

  // per-output fine delay line, counted in clk_sys cycles
  for (genvar y = 0; y < NUM_OUT; y++) begin : g_out
    localparam logic [2:0] CH = ch_of_out(y);
    logic [3:0] hist_r;
    logic sref;
    logic bypass;
    assign sref = ctrl_r[CH][`OCD_CTRL_SYSREF_BIT];
    assign bypass = is_rf_ch(CH) && ctrl_r[CH][`OCD_CTRL_EXT_OSC_BIT];

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        hist_r <= 4'h0;
        out_level[y] <= 1'b0;
        output_analog_delay[y*`OCD_ANLG_W +: `OCD_ANLG_W] <= '0;
      end else begin
        hist_r <= {hist_r[2:0], ch_level[CH]};
        if (bypass) begin
          out_level[y] <= rf_oscillator_pin;
        end else if (sref) begin
          out_level[y] <= hist_r[outdly_r[y][`OCD_FINE_LSB +: `OCD_FINE_W]];
        end else begin
          out_level[y] <= hist_r[0]; // clock mode ignores fine delay
        end
        // analog delay code only reaches the output stage in sysref mode
        output_analog_delay[y*`OCD_ANLG_W +: `OCD_ANLG_W] <=
          (sref && !bypass) ? outdly_r[y][`OCD_ANLG_LSB +: `OCD_ANLG_W] : '0;
      end
    end
  end

endmodule

//--- ocd_params.svh
// Purpose: register offsets, field positions, reset values and limits of the output channel block
// Assumes: 8-bit registers on the serial configuration port, 7-bit address
// Notes: included by the package and by the design modules
`ifndef OCD_PARAMS_SVH
`define OCD_PARAMS_SVH

`define OCD_NUM_CH 8
`define OCD_NUM_OUT 16
`define OCD_ADDR_W 7
`define OCD_DATA_W 8
// shared sysref stage setting and control
`define OCD_SYSREF_SHARED_ADDR 7'h38
`define OCD_SYNC_ADDR 7'h39
`define OCD_STATUS_ADDR 7'h3A
// per channel block: base + 4*ch
`define OCD_CH_BASE 7'h40
`define OCD_CH_CTRL_OFS 2'h0
`define OCD_CH_STAGE_A_OFS 2'h1
`define OCD_CH_STAGE_B_OFS 2'h2
`define OCD_CH_WIDE_OFS 2'h3
// per output block: base + y
`define OCD_OUT_BASE 7'h60
// channel control fields
`define OCD_CTRL_SYSREF_BIT 0
`define OCD_CTRL_EXT_OSC_BIT 1
`define OCD_CTRL_WIDE_MSB_BIT 2
`define OCD_CTRL_SRC_BIT 3
// output delay fields
`define OCD_FINE_LSB 0
`define OCD_ANLG_LSB 2
// reset values
`define OCD_RST_CTRL 8'h00
`define OCD_RST_STAGE_A 8'h01
`define OCD_RST_STAGE_B 8'h00
`define OCD_RST_WIDE 8'h00
`define OCD_RST_OUT 8'h00
`define OCD_RST_SHARED 8'h00
// ratio limits: stage a 1..20, stage b 2**0..2**10, shared stage 2**0..2**12
`define OCD_STAGE_A_MAX 5'd20
`define OCD_STAGE_B_MAX 4'd10
`define OCD_SHARED_MAX 4'd12
`define OCD_RATIO_W 27
`define OCD_WIDE_W 9
`define OCD_FINE_W 2
`define OCD_ANLG_W 3
`define OCD_SYNC_BIT 0

`endif

//--- ocd_pkg.sv
// Purpose: types and shared helpers for the output channel block
// Assumes: ocd_params.svh holds every number
// Notes: helper functions clamp ratio codes to the legal discrete set
`include "ocd_params.svh"
package ocd_pkg;

  // serial port phases, gray along idle -> address -> data
  typedef enum logic [1:0] {
    OCD_SPI_IDLE = 2'b00,
    OCD_SPI_ADDR = 2'b01,
    OCD_SPI_DATA = 2'b11
  } ocd_spi_state_type;

  typedef logic [`OCD_RATIO_W-1:0] ocd_ratio_type;

  // stage a: 0 and out-of-range codes fall back to the nearest legal ratio
  function automatic logic [4:0] ocd_stage_a(input logic [7:0] code);
    if (code == 8'h00) return 5'd1;
    if (code > 8'(`OCD_STAGE_A_MAX)) return `OCD_STAGE_A_MAX;
    return code[4:0];
  endfunction

  // power-of-two stage exponent, clamped to its maximum
  function automatic logic [3:0] ocd_exp(input logic [7:0] code, input logic [3:0] max_exp);
    if (code > 8'(max_exp)) return max_exp;
    return code[3:0];
  endfunction

endpackage

//--- ocd_channel_divider.sv
// Purpose: one output channel divider with shared sysref stage and wide phase delay
// Assumes: src_tick marks one period of the selected source, one clk_sys cycle wide
// Notes: the three serial stages are realised as one counter on their product
`timescale 1ns/100ps
`include "ocd_params.svh"
module ocd_channel_divider
  import ocd_pkg::*;
#(
  parameter int CNT_W = `OCD_RATIO_W,
  parameter int WIDE_W = `OCD_WIDE_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic src_tick,
  input wire logic sysref_mode,
  input wire logic [4:0] stage_a,
  input wire logic [3:0] stage_b_exp,
  input wire logic [3:0] shared_exp,
  input wire logic [WIDE_W-1:0] wide_delay,
  input wire logic sync,
  output logic level
);

  if (CNT_W < `OCD_RATIO_W) begin : g_chk
    $error("ocd_channel_divider: CNT_W too small for the largest ratio");
  end

  logic [CNT_W-1:0] ratio;
  logic [CNT_W-1:0] cnt_r;
  logic [WIDE_W-1:0] wait_r;
  logic run_r;

  // clock mode: a * 2**b; sysref mode adds the shared stage
  always_comb begin
    ratio = CNT_W'(stage_a) << (CNT_W'(stage_b_exp) + (sysref_mode ? CNT_W'(shared_exp) : CNT_W'(0)));
  end

  // restart on sync, hold off by the wide delay, then count source periods
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= '0;
      wait_r <= '0;
      run_r <= 1'b0;
    end else if (sync) begin
      cnt_r <= '0;
      wait_r <= wide_delay;
      run_r <= (wide_delay == '0);
    end else if (src_tick) begin
      if (!run_r) begin
        if (wait_r <= WIDE_W'(1)) begin
          run_r <= 1'b1;
        end
        wait_r <= wait_r - WIDE_W'(1);
      end else if (cnt_r >= ratio - CNT_W'(1)) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  // first half of each divided period high; ratio 1 passes the source
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level <= 1'b0;
    end else if (!run_r || sync) begin
      level <= 1'b0; // held low while the phase delay runs off
    end else if (ratio == CNT_W'(1)) begin
      level <= src_tick;
    end else begin
      level <= (cnt_r < (ratio >> 1));
    end
  end

endmodule

//--- ocd_output_monitor.sv
// Purpose: port checker for the output channel block
// Assumes: frames are two bytes; writes are snooped to mirror modes
// Notes: mirrors update in the same cycle as the design registers but outputs trail them, so stable windows are used
`timescale 1ns/100ps
`include "ocd_params.svh"
module ocd_output_monitor
  import ocd_pkg::*;
#(
  parameter int NUM_CH = `OCD_NUM_CH,
  parameter int NUM_OUT = `OCD_NUM_OUT
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso_oe_n,
  input wire logic rf_oscillator_pin,
  input wire logic [NUM_OUT-1:0] out_level,
  input wire logic [NUM_OUT*`OCD_ANLG_W-1:0] output_analog_delay
);
  logic sclk_q_r;
  logic [4:0] cnt_r;
  logic [15:0] sh_r;
  logic [15:0] word;
  logic [7:0] sys_r;
  logic [1:0] byp_r;
  logic [7:0] clk_ch;
  logic [47:0] amask;
  assign word = {sh_r[14:0], spi_mosi};
  // count and shift serial bits of the current frame
  always_ff @(posedge clk_sys) begin
    sclk_q_r <= spi_sclk;
    if (reset || spi_cs_n) begin
      cnt_r <= 5'h00;
    end else if (spi_sclk && !sclk_q_r && cnt_r != 5'h10) begin
      cnt_r <= cnt_r + 5'h01;
      sh_r <= word;
    end
  end
  // mirror of mode and bypass bits, taken at the last bit of a control write
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sys_r <= 8'h00;
      byp_r <= 2'h0;
    end else if (spi_sclk && !sclk_q_r && !spi_cs_n && cnt_r == 5'h0F && word[15:13] == 3'h2 && word[9:8] == 2'h0) begin
      sys_r[word[12:10]] <= word[0];
      if (word[12:10] == 3'h2) byp_r[0] <= word[1];
      if (word[12:10] == 3'h3) byp_r[1] <= word[1];
    end
  end
  // outputs whose channel has no per-output delay (clock mode or bypass)
  assign clk_ch = ~sys_r | {4'h0, byp_r, 2'h0};
  assign amask = {{9{clk_ch[7]}}, {3{clk_ch[6]}}, {6{clk_ch[5]}}, {9{clk_ch[4]}}, {6{clk_ch[3]}}, {6{clk_ch[2]}},
    {6{clk_ch[1]}}, {3{clk_ch[0]}}};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  reset_clear_a: assert property ($past(reset) |-> out_level == '0 && output_analog_delay == '0 && spi_miso_oe_n)
    else $error("outputs not cleared by reset");
  idle_release_a: assert property ($past(spi_cs_n) |-> spi_miso_oe_n)
    else $error("miso driven outside a frame");
  read_start_a: assert property ($fell(spi_miso_oe_n) |-> cnt_r == 5'h08 && sh_r[7])
    else $error("miso driven not after a read command byte");
  read_end_a: assert property (cnt_r == 5'h10 |-> ##[0:2] spi_miso_oe_n)
    else $error("miso still driven after the data byte");
  bypass_c_a: assert property (byp_r[0] && $past(byp_r[0], 3) |-> out_level[4:3] == {2{$past(rf_oscillator_pin)}})
    else $error("rf channel c does not copy the oscillator");
  bypass_d_a: assert property (byp_r[1] && $past(byp_r[1], 3) |-> out_level[6:5] == {2{$past(rf_oscillator_pin)}})
    else $error("rf channel d does not copy the oscillator");
  analog_off_a: assert property ((amask & $past(amask, 4) & output_analog_delay) == 48'h0)
    else $error("analog delay present on a clock output");
  equal_b_a: assert property (!sys_r[1] && !$past(sys_r[1], 6) |-> out_level[2] == out_level[1])
    else $error("channel b outputs differ in clock mode");
  equal_e_a: assert property (!sys_r[4] && !$past(sys_r[4], 6) |-> out_level[9:7] == {3{out_level[7]}})
    else $error("channel e outputs differ in clock mode");
  equal_h_a: assert property (!sys_r[7] && !$past(sys_r[7], 6) |-> out_level[15:13] == {3{out_level[13]}})
    else $error("channel h outputs differ in clock mode");
endmodule
bind ocd_output_channels ocd_output_monitor #(.NUM_CH(NUM_CH), .NUM_OUT(NUM_OUT)) i_ocd_output_monitor (
  .clk_sys(clk_sys), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
  .spi_miso_oe_n(spi_miso_oe_n), .rf_oscillator_pin(rf_oscillator_pin), .out_level(out_level),
  .output_analog_delay(output_analog_delay));

//--- ocd_converter_model.sv
// Purpose: converter side model counting rising edges of every output
// Assumes: a converter acts on rising edges only
// Notes: counters wrap; users work on differences
`timescale 1ns/100ps
`include "ocd_params.svh"
module ocd_converter_model
  import ocd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [`OCD_NUM_OUT-1:0] out_level,
  output logic [`OCD_NUM_OUT-1:0][15:0] edges
);
  logic [`OCD_NUM_OUT-1:0] prev_r;
  // one counter per output so a misrouted channel shows up
  always_ff @(posedge clk_sys) begin
    prev_r <= out_level;
    for (int y = 0; y < `OCD_NUM_OUT; y++) begin
      if (reset) edges[y] <= 16'h0000;
      else if (out_level[y] && !prev_r[y]) edges[y] <= edges[y] + 16'h0001;
    end
  end
endmodule

//--- ocd_output_channels_bench.sv
// Purpose: self-checking bench for the output channel block
// Assumes: pll1 ticks every 2nd cycle, pll0 every 3rd cycle
// Notes: ratios are judged by edge counts over a window, so one edge of slack
`timescale 1ns/100ps
module ocd_output_channels_bench
  import ocd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic spi_sclk = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_mosi = 1'b0;
  logic src_pll1_tick = 1'b0;
  logic src_pll0_tick = 1'b0;
  logic rf_oscillator_pin = 1'b0;
  logic pin_q = 1'b0;
  logic spi_miso, spi_miso_oe_n;
  logic [15:0] out_level;
  logic [47:0] output_analog_delay;
  logic [15:0][15:0] edges;
  logic [15:0] lfsr_r = 16'h4337;
  logic [1:0] tick3_r = 2'h0;
  logic [7:0] rd;
  logic [3:0] h = 4'h0;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int first[9] = '{0, 1, 3, 5, 7, 10, 12, 13, 16};
  int a, b, ac, bc, t0, t1;
  always #5 clk_sys = ~clk_sys;
  ocd_output_channels i_ocd_output_channels (.clk_sys(clk_sys), .reset(reset), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
    .src_pll1_tick(src_pll1_tick), .src_pll0_tick(src_pll0_tick), .rf_oscillator_pin(rf_oscillator_pin),
    .out_level(out_level), .output_analog_delay(output_analog_delay));
  ocd_converter_model i_ocd_converter_model (.clk_sys(clk_sys), .reset(reset), .out_level(out_level), .edges(edges));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected edges in w cycles; stage a codes clamp to 1..20
  function automatic int exp_edges(input int w, input int a, input int b, input int sh, input int p);
    int r;
    r = (a == 0) ? 1 : (a > 20) ? 20 : a;
    return w / (r * (1 << b) * (1 << sh) * p);
  endfunction
  // sources, a noisy oscillator pin and the hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    lfsr_r <= lfsr_next(lfsr_r);
    rf_oscillator_pin <= lfsr_r[0];
    pin_q <= rf_oscillator_pin;
    src_pll1_tick <= ~src_pll1_tick;
    tick3_r <= (tick3_r == 2'h2) ? 2'h0 : tick3_r + 2'h1;
    src_pll0_tick <= (tick3_r == 2'h2);
    if (cyc == 60000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
    checks++;
    if (got !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, got);
    end
  endtask
  task automatic near(input string what, input int e, input int got, input int tol);
    checks++;
    if (got < e - tol || got > e + tol) begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, e, got);
    end
  endtask
  // one two-byte frame; miso is taken at the end of the high phase, one data bit per rise 9..16
  task automatic spi(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] q);
    logic [15:0] w;
    w = {cmd, dat};
    q = 8'h00;
    @(posedge clk_sys);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      spi_mosi <= w[15 - i];
      spi_sclk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      if (i >= 8) q[15 - i] = spi_miso;
      spi_sclk <= 1'b0;
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  // edge counts of every output of channel c over w cycles
  task automatic measure(input int c, input int e, input int w);
    logic [15:0][15:0] s;
    repeat (400) @(posedge clk_sys);
    s = edges;
    repeat (w) @(posedge clk_sys);
    for (int y = first[c]; y < first[c + 1]; y++) near("edges", e, int'(16'(edges[y] - s[y])), 1);
  endtask
  task automatic rise_wait(output int t);
    t = 0;
    while (out_level[1] !== 1'b1 && t < 300) begin
      @(posedge clk_sys);
      t++;
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    // defaults, a read-only status and an unmapped place
    spi(8'hC1, 8'h00, rd);
    chk("stage a reset", 8'h01, rd);
    spi(8'hB8, 8'h00, rd);
    chk("shared reset", 8'h00, rd);
    spi(8'h3A, 8'hFF, rd);
    spi(8'hBA, 8'h00, rd);
    chk("status read only", 8'h00, rd);
    spi(8'hBB, 8'h00, rd);
    chk("unmapped", 8'h00, rd);
    // random ratios per channel, clamp corners first, odd channels fed by pll0
    for (int c = 0; c < 8; c++) begin
      a = (c == 0) ? 0 : (c == 1) ? 25 : 1 + lfsr_r % 20;
      b = lfsr_r[9:8] % 3;
      if (c == 2) ac = a;
      if (c == 2) bc = b;
      spi(8'(8'h41 + 4 * c), 8'(a), rd);
      spi(8'(8'h42 + 4 * c), 8'(b), rd);
      spi(8'(8'h40 + 4 * c), c[0] ? 8'h08 : 8'h00, rd);
      measure(c, exp_edges(3000, a, b, 0, c[0] ? 3 : 2), 3000);
    end
    // sysref on f at 3*2*4 beside clock a at 6, so a divides the sysref input
    spi(8'h41, 8'h03, rd);
    spi(8'h42, 8'h01, rd);
    spi(8'h38, 8'h02, rd);
    spi(8'h55, 8'h03, rd);
    spi(8'h56, 8'h01, rd);
    spi(8'h54, 8'h01, rd);
    spi(8'hBA, 8'h00, rd);
    chk("status", 8'h20, rd);
    spi(8'hB8, 8'h00, rd);
    chk("shared", 8'h02, rd);
    measure(5, exp_edges(3000, 3, 1, 2, 2), 3000);
    // analog code reaches only its own output and only in sysref mode
    spi(8'h6A, 8'h17, rd);
    repeat (4) @(posedge clk_sys);
    chk("analog sysref", 8'h05, 8'(output_analog_delay[32:30]));
    chk("analog neighbour", 8'h00, 8'(output_analog_delay[35:33]));
    // fine delay 3 on output 10 makes it trail its neighbour by three cycles
    repeat (3) begin
      @(posedge clk_sys);
      h = {h[2:0], out_level[11]};
    end
    repeat (48) begin
      @(posedge clk_sys);
      h = {h[2:0], out_level[11]};
      chk("fine delay", {7'h0, h[3]}, {7'h0, out_level[10]});
    end
    spi(8'h54, 8'h00, rd);
    repeat (4) @(posedge clk_sys);
    chk("analog clock mode", 8'h00, 8'(output_analog_delay[32:30]));
    // clock mode ignores the fine setting, so both outputs move together
    repeat (24) begin
      @(posedge clk_sys);
      chk("fine off in clock mode", {7'h0, out_level[11]}, {7'h0, out_level[10]});
    end
    // wide delay holds the first edge back by 20 pll0 ticks more, 3 cycles each
    spi(8'h47, 8'h14, rd);
    rise_wait(t0);
    spi(8'h47, 8'h28, rd);
    rise_wait(t1);
    near("wide delay", 60, t1 - t0, 2);
    // c and d in bypass copy the pin, then c returns to its divider
    spi(8'h48, 8'h02, rd);
    spi(8'h4C, 8'h02, rd);
    repeat (8) begin
      @(posedge clk_sys);
      chk("bypass copy", {4'h0, {4{pin_q}}}, {4'h0, out_level[6:3]});
    end
    spi(8'h4C, 8'h00, rd);
    spi(8'h48, 8'h00, rd);
    measure(2, exp_edges(3000, ac, bc, 0, 2), 3000);
    // a second reset restores defaults
    reset <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("outputs in reset", 8'h00, out_level[7:0]);
    reset <= 1'b0;
    spi(8'hC1, 8'h00, rd);
    chk("stage a after reset", 8'h01, rd);
    tally_and_finish();
  end
endmodule
